/* uart_irq_pkg.sv */
// Package for the per-channel interrupt and FIFO control block.
// Assumes one clock domain; offsets are register indices on a 3-bit plain port.
package uart_irq_pkg;
  // Register indices (read and write share index 2 for status/fifo control)
  localparam logic [2:0] ADDR_RECEIVE_HOLDING = 3'h0;
  localparam logic [2:0] ADDR_INTERRUPT_ENABLE = 3'h1;
  localparam logic [2:0] ADDR_INTERRUPT_STATUS = 3'h2;
  localparam logic [2:0] ADDR_FIFO_CONTROL = 3'h2;
  localparam logic [2:0] ADDR_LINE_STATUS = 3'h5;
  localparam logic [2:0] ADDR_MODEM_STATUS = 3'h6;
  localparam logic [2:0] ADDR_ENHANCED_FEATURE = 3'h7;

  // Interrupt enable fields
  localparam int IE_RX_DATA = 0;
  localparam int IE_TX_READY = 1;
  localparam int IE_LINE = 2;
  localparam int IE_MODEM = 3;
  localparam int IE_SLEEP = 4;
  localparam int IE_XOFF = 5;
  localparam int IE_RTS = 6;
  localparam int IE_CTS = 7;
  localparam logic [7:0] IE_RESET = 8'h00;
  localparam logic [7:0] IE_BASIC_MASK = 8'h0F;

  // Enhanced feature fields
  localparam int EF_ENHANCED = 4;
  localparam int EF_AUTO_RTS = 6;
  localparam int EF_AUTO_CTS = 7;
  localparam logic [7:0] EF_RESET = 8'h00;

  // FIFO control fields
  localparam int FC_ENABLE = 0;
  localparam int FC_RX_RESET = 1;
  localparam int FC_TX_RESET = 2;
  localparam logic [7:0] FC_RESET = 8'h00;

  // Status encodings, bits 5..0
  localparam logic [5:0] ISR_LINE = 6'h06;
  localparam logic [5:0] ISR_RX_TIMEOUT = 6'h0C;
  localparam logic [5:0] ISR_RX_DATA = 6'h04;
  localparam logic [5:0] ISR_TX_READY = 6'h02;
  localparam logic [5:0] ISR_MODEM = 6'h00;
  localparam logic [5:0] ISR_XOFF = 6'h10;
  localparam logic [5:0] ISR_FLOW_PIN = 6'h20;
  localparam logic [5:0] ISR_NONE = 6'h01;

  // Receive time-out: four characters plus twelve bits, in bit times
  localparam int TIMEOUT_CHARS = 4;
  localparam int TIMEOUT_EXTRA_BITS = 12;
  localparam int BITS_PER_CHAR_MAX = 12;
  localparam int TIMEOUT_BITS = TIMEOUT_CHARS * BITS_PER_CHAR_MAX + TIMEOUT_EXTRA_BITS;
  localparam logic [6:0] TIMEOUT_BITS_W = 7'(TIMEOUT_BITS);

  typedef enum logic [1:0] {
    FLOW_IDLE,
    FLOW_XOFF,
    FLOW_SPECIAL
  } xoff_kind_t;
endpackage

/* uart_irq_ctrl.sv */
// Per-channel interrupt enable, prioritised status and FIFO control.
// Assumes receiver, transmitter and modem logic on clk give one-cycle event
// pulses and levels; flow-control pins arrive asynchronously.
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module uart_irq_ctrl
  import uart_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rd_data,
  input wire logic rx_data_avail,
  input wire logic rx_char_in,
  input wire logic bit_tick,
  input wire logic tx_holding_empty,
  input wire logic [4:1] line_status_bits,
  input wire logic [3:0] modem_change_bits,
  input wire logic xoff_detect,
  input wire logic special_detect,
  input wire logic xon_detect,
  input wire logic rts_pin,
  input wire logic cts_pin,
  output logic irq,
  output logic sleep_enable,
  output logic fifo_enable,
  output logic rx_fifo_reset,
  output logic tx_fifo_reset
);

  logic [7:0] ie_q;
  logic [7:0] ef_q;
  logic fifo_en_q;
  logic rx_rst_q;
  logic tx_rst_q;
  logic [7:0] rd_q;
  logic irq_q;
  logic tx_pend_q;
  logic tx_empty_q;
  logic line_pend_q;
  logic modem_pend_q;
  logic timeout_q;
  logic [6:0] to_cnt_q;
  xoff_kind_t xkind_q;
  logic flow_pend_q;
  logic [1:0] rts_sync_q;
  logic [1:0] cts_sync_q;
  logic rts_prev_q;
  logic cts_prev_q;
  logic [5:0] code;
  logic any_pend;

  wire logic wr_ie = wr_stb && addr == ADDR_INTERRUPT_ENABLE;
  wire logic wr_fc = wr_stb && addr == ADDR_FIFO_CONTROL;
  wire logic rd_isr = rd_stb && addr == ADDR_INTERRUPT_STATUS;
  wire logic rd_line = rd_stb && addr == ADDR_LINE_STATUS;
  wire logic rd_modem = rd_stb && addr == ADDR_MODEM_STATUS;
  wire logic rd_hold = rd_stb && addr == ADDR_RECEIVE_HOLDING;
  wire logic enh = ef_q[EF_ENHANCED];

  // Enhanced feature register kept here so gating bits are local
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ef_q <= EF_RESET;
    end else if (wr_stb && addr == ADDR_ENHANCED_FEATURE) begin
      ef_q <= wr_data;
    end
  end

  // Upper enable bits only take writes in enhanced mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ie_q <= IE_RESET;
    end else if (wr_ie) begin
      if (enh) begin
        ie_q <= wr_data;
      end else begin
        ie_q <= {ie_q[7:4], wr_data[3:0]};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_en_q <= FC_RESET[FC_ENABLE];
      rx_rst_q <= 1'b0;
      tx_rst_q <= 1'b0;
    end else begin
      rx_rst_q <= 1'b0;
      tx_rst_q <= 1'b0;
      if (wr_fc) begin
        fifo_en_q <= wr_data[FC_ENABLE];
        rx_rst_q <= wr_data[FC_ENABLE] & wr_data[FC_RX_RESET];
        tx_rst_q <= wr_data[FC_ENABLE] & wr_data[FC_TX_RESET];
      end
    end
  end

  // Transmit ready: set on empty edge or enable while empty; set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Idle high so an empty holding register at reset is no false edge
      tx_empty_q <= 1'b1;
      tx_pend_q <= 1'b0;
    end else begin
      tx_empty_q <= tx_holding_empty;
      if ((tx_holding_empty && !tx_empty_q) ||
          (wr_ie && wr_data[IE_TX_READY] && !ie_q[IE_TX_READY] && tx_holding_empty)) begin
        tx_pend_q <= 1'b1;
      end else if ((rd_isr && code == ISR_TX_READY) ||
                   (wr_stb && addr == ADDR_RECEIVE_HOLDING)) begin
        tx_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_pend_q <= 1'b0;
      modem_pend_q <= 1'b0;
    end else begin
      if (|line_status_bits) begin
        line_pend_q <= 1'b1;
      end else if (rd_line) begin
        line_pend_q <= 1'b0;
      end
      if (|modem_change_bits) begin
        modem_pend_q <= 1'b1;
      end else if (rd_modem) begin
        modem_pend_q <= 1'b0;
      end
    end
  end

  // Time-out counts bit ticks while data waits, restarts on any char or receive holding read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      to_cnt_q <= 7'h00;
      timeout_q <= 1'b0;
    end else begin
      if (!rx_data_avail || rx_char_in || rd_hold) begin
        to_cnt_q <= 7'h00;
      end else if (bit_tick && to_cnt_q != TIMEOUT_BITS_W) begin
        to_cnt_q <= to_cnt_q + 7'h01;
      end
      if (bit_tick && rx_data_avail && !rx_char_in && !rd_hold &&
          to_cnt_q == TIMEOUT_BITS_W - 7'h01) begin
        timeout_q <= 1'b1;
      end else if (rd_hold || !rx_data_avail) begin
        timeout_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xkind_q <= FLOW_IDLE;
    end else begin
      if (xoff_detect) begin
        xkind_q <= FLOW_XOFF;
      end else if (special_detect) begin
        xkind_q <= FLOW_SPECIAL;
      end else begin
        case (xkind_q)
          FLOW_XOFF: begin
            if (xon_detect || (rd_isr && code == ISR_XOFF)) begin
              xkind_q <= FLOW_IDLE;
            end
          end
          FLOW_SPECIAL: begin
            if (rx_char_in || (rd_isr && code == ISR_XOFF)) begin
              xkind_q <= FLOW_IDLE;
            end
          end
          default: xkind_q <= FLOW_IDLE;
        endcase
      end
    end
  end

  // Pins pass two flops before edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rts_sync_q <= 2'b00;
      cts_sync_q <= 2'b00;
      rts_prev_q <= 1'b0;
      cts_prev_q <= 1'b0;
    end else begin
      rts_sync_q <= {rts_sync_q[0], rts_pin};
      cts_sync_q <= {cts_sync_q[0], cts_pin};
      rts_prev_q <= rts_sync_q[1];
      cts_prev_q <= cts_sync_q[1];
    end
  end

  wire logic rts_rise = rts_sync_q[1] && !rts_prev_q && ef_q[EF_AUTO_RTS];
  wire logic cts_rise = cts_sync_q[1] && !cts_prev_q && ef_q[EF_AUTO_CTS];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flow_pend_q <= 1'b0;
    end else if ((rts_rise && ie_q[IE_RTS]) || (cts_rise && ie_q[IE_CTS])) begin
      flow_pend_q <= 1'b1;
    end else if (rd_modem) begin
      flow_pend_q <= 1'b0;
    end
  end

  // Fixed priority picks one source; the rest stay pending
  always_comb begin
    code = ISR_NONE;
    if (ie_q[IE_LINE] && line_pend_q) begin
      code = ISR_LINE;
    end else if (ie_q[IE_RX_DATA] && timeout_q) begin
      code = ISR_RX_TIMEOUT;
    end else if (ie_q[IE_RX_DATA] && rx_data_avail) begin
      code = ISR_RX_DATA;
    end else if (ie_q[IE_TX_READY] && tx_pend_q) begin
      code = ISR_TX_READY;
    end else if (ie_q[IE_MODEM] && modem_pend_q) begin
      code = ISR_MODEM;
    end else if (enh && ie_q[IE_XOFF] && xkind_q != FLOW_IDLE) begin
      code = ISR_XOFF;
    end else if (enh && flow_pend_q && (ie_q[IE_RTS] || ie_q[IE_CTS])) begin
      code = ISR_FLOW_PIN;
    end
    any_pend = code != ISR_NONE;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 8'h00;
    end else if (rd_isr) begin
      rd_q <= {fifo_en_q, fifo_en_q, code};
    end else if (rd_stb && addr == ADDR_INTERRUPT_ENABLE) begin
      rd_q <= ie_q;
    end else if (rd_stb && addr == ADDR_ENHANCED_FEATURE) begin
      rd_q <= ef_q;
    end else begin
      rd_q <= 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= any_pend;
    end
  end

  assign rd_data = rd_q;
  assign irq = irq_q;
  assign sleep_enable = ie_q[IE_SLEEP];
  assign fifo_enable = fifo_en_q;
  assign rx_fifo_reset = rx_rst_q;
  assign tx_fifo_reset = tx_rst_q;

endmodule
`default_nettype wire

/* uart_irq_chk.sv */
// Checker for uart_irq_ctrl port relations.
// Assumes one clk domain; bound to every uart_irq_ctrl instance.
`timescale 1ns/1ps
`default_nettype none
module uart_irq_chk
  import uart_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rd_data,
  input wire logic irq,
  input wire logic sleep_enable,
  input wire logic fifo_enable,
  input wire logic rx_fifo_reset,
  input wire logic tx_fifo_reset
);
  logic enh_q;
  wire fc_wr = wr_stb && addr == ADDR_FIFO_CONTROL;
  wire ie_wr = wr_stb && addr == ADDR_INTERRUPT_ENABLE;
  wire st_rd = rd_stb && addr == ADDR_INTERRUPT_STATUS;
  // Shadow of the enhanced bit; the register itself is not visible here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) enh_q <= 1'b0;
    else if (wr_stb && addr == ADDR_ENHANCED_FEATURE) enh_q <= wr_data[EF_ENHANCED];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_RX_RST: assert property (rx_fifo_reset |-> $past(fc_wr && wr_data[1:0] == 2'h3))
    else $error("receive reset without enabled write");
  AST_TX_RST: assert property (tx_fifo_reset |-> $past(fc_wr && wr_data[0] && wr_data[2]))
    else $error("transmit reset without enabled write");
  AST_RST_PULSE: assert property (rx_fifo_reset && !wr_stb |=> !rx_fifo_reset)
    else $error("receive reset longer than one cycle");
  AST_FEN: assert property ($past(fc_wr) |-> fifo_enable == $past(wr_data[FC_ENABLE]))
    else $error("fifo enable not taken from write");
  AST_ISR_TOP: assert property ($past(st_rd) |-> rd_data[7:6] == {2{$past(fifo_enable)}})
    else $error("status top bits differ from fifo enable");
  AST_ISR_NONE: assert property ($past(st_rd) && rd_data[0] |-> rd_data[5:1] == 5'h00)
    else $error("idle status code wrong");
  AST_SLEEP: assert property ($rose(sleep_enable) |-> $past(ie_wr && wr_data[4] && enh_q))
    else $error("sleep set without enhanced write");
  AST_IRQ_OFF: assert property (ie_wr && wr_data == 8'h00 |-> ##3 !irq)
    else $error("irq stays with all sources disabled");
endmodule
bind uart_irq_ctrl uart_irq_chk chk (.clk, .rst_n, .addr, .wr_data, .wr_stb, .rd_stb,
  .rd_data, .irq, .sleep_enable, .fifo_enable, .rx_fifo_reset, .tx_fifo_reset);
`default_nettype wire

/* host_bus_model.sv */
// Host side of the register port: one-cycle write and read strobes.
// Assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input wire logic clk,
  output logic [2:0] addr = 3'h0,
  output logic [7:0] wr_data = 8'h00,
  output logic wr_stb = 1'b0,
  output logic rd_stb = 1'b0,
  input wire logic [7:0] rd_data
);
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wr_data <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 v = rd_data;
  endtask
endmodule
`default_nettype wire

/* test_uart_interrupt_and_fifo_control.sv */
// Testbench for uart_irq_ctrl: register sequences with expected values.
// Assumes host_bus_model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_uart_interrupt_and_fifo_control
  import uart_irq_pkg::*;
();
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rx_data_avail = 1'b0;
  logic tx_holding_empty = 1'b1;
  logic [4:1] line_status_bits = 4'h0;
  logic [3:0] modem_change_bits = 4'h0;
  logic xoff_detect = 1'b0;
  logic cts_pin = 1'b0;
  logic bit_tick = 1'b0;
  logic [2:0] addr;
  logic [7:0] wr_data, rd_data, d;
  logic wr_stb, rd_stb, irq, sleep_enable, fifo_enable, rx_fifo_reset, tx_fifo_reset;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int n_rxr = 0;
  int n_txr = 0;
  host_bus_model host (.clk(clk), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data));
  // No new characters arrive here; bit ticks drive the time-out
  uart_irq_ctrl dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .rx_data_avail(rx_data_avail),
    .rx_char_in(1'b0), .bit_tick(bit_tick), .tx_holding_empty(tx_holding_empty),
    .line_status_bits(line_status_bits), .modem_change_bits(modem_change_bits),
    .xoff_detect(xoff_detect), .special_detect(1'b0), .xon_detect(1'b0),
    .rts_pin(1'b0), .cts_pin(cts_pin), .irq(irq), .sleep_enable(sleep_enable),
    .fifo_enable(fifo_enable), .rx_fifo_reset(rx_fifo_reset),
    .tx_fifo_reset(tx_fifo_reset));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic interrupt_status(input logic [7:0] exp);
    host.rd(ADDR_INTERRUPT_STATUS, d);
    chk("status", d, exp);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (rx_fifo_reset === 1'b1) n_rxr++;
    if (tx_fifo_reset === 1'b1) n_txr++;
    if (cycles == 5000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    interrupt_status(8'h01);
    chk("irq", {7'h00, irq}, 8'h00);
    host.wr(ADDR_INTERRUPT_ENABLE, 8'h02);
    settle();
    chk("irq", {7'h00, irq}, 8'h01);
    interrupt_status(8'h02);
    interrupt_status(8'h01);
    host.wr(ADDR_INTERRUPT_ENABLE, 8'h0D);
    rx_data_avail <= 1'b1;
    line_status_bits <= 4'h2;
    modem_change_bits <= 4'h1;
    @(posedge clk);
    line_status_bits <= 4'h0;
    modem_change_bits <= 4'h0;
    settle();
    interrupt_status(8'h06);
    host.rd(ADDR_LINE_STATUS, d);
    interrupt_status(8'h04);
    @(posedge clk);
    rx_data_avail <= 1'b0;
    settle();
    interrupt_status(8'h00);
    host.rd(ADDR_MODEM_STATUS, d);
    interrupt_status(8'h01);
    host.rd(3'h3, d);
    chk("unmapped", d, 8'h00);
    host.wr(ADDR_FIFO_CONTROL, 8'h06);
    settle();
    chk("fifo_rst", 8'(n_rxr + n_txr), 8'h00);
    host.wr(ADDR_FIFO_CONTROL, 8'h07);
    settle();
    chk("rx_rst", 8'(n_rxr), 8'h01);
    chk("tx_rst", 8'(n_txr), 8'h01);
    interrupt_status(8'hC1);
    host.wr(ADDR_FIFO_CONTROL, 8'h00);
    settle();
    chk("fifo_en", {7'h00, fifo_enable}, 8'h00);
    host.wr(ADDR_INTERRUPT_ENABLE, 8'h10);
    settle();
    chk("sleep", {7'h00, sleep_enable}, 8'h00);
    host.wr(ADDR_ENHANCED_FEATURE, 8'h90);
    host.wr(ADDR_INTERRUPT_ENABLE, 8'hB0);
    settle();
    chk("sleep", {7'h00, sleep_enable}, 8'h01);
    xoff_detect <= 1'b1;
    @(posedge clk);
    xoff_detect <= 1'b0;
    settle();
    interrupt_status(8'h10);
    interrupt_status(8'h01);
    @(posedge clk);
    cts_pin <= 1'b1;
    repeat (6) @(posedge clk);
    interrupt_status(8'h20);
    host.rd(ADDR_MODEM_STATUS, d);
    interrupt_status(8'h01);
    host.wr(ADDR_INTERRUPT_ENABLE, 8'h01);
    rx_data_avail <= 1'b1;
    bit_tick <= 1'b1;
    repeat (TIMEOUT_BITS - 1) @(posedge clk);
    bit_tick <= 1'b0;
    settle();
    interrupt_status(8'h04);
    bit_tick <= 1'b1;
    @(posedge clk);
    bit_tick <= 1'b0;
    settle();
    interrupt_status(8'h0C);
    host.rd(ADDR_RECEIVE_HOLDING, d);
    interrupt_status(8'h04);
    rx_data_avail <= 1'b0;
    settle();
    host.wr(ADDR_INTERRUPT_ENABLE, 8'h00);
    settle();
    chk("irq", {7'h00, irq}, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
